// file: pkg/ecd_pkg.sv
package ecd_pkg;

	// System clock and the four-phase timing rate.
	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned PHASE_RATE_PPS  = 12_800;
	localparam int unsigned PHASES_PER_TURN = 4;

	// Clock cycles spent in each phase slot; a longest time, so it rounds down.
	localparam int unsigned PHASE_CYCLES = CLK_HZ / (PHASE_RATE_PPS * PHASES_PER_TURN);

	// Error counter geometry.
	localparam int unsigned COUNT_W   = 9;
	localparam logic [8:0]  SAT_COUNT = 9'h180;
	localparam logic [8:0]  ZERO_COUNT = 9'h000;

	// Reset values of the control flip-flops.
	localparam logic RST_SIGN_POS = 1'b1;
	localparam logic RST_DIR_UP   = 1'b1;
	localparam logic RST_CMD_POL  = 1'b1;

	// Synchroniser depth for pin inputs.
	localparam int unsigned SYNC_STAGES = 3;

	// Phase slot of the four-phase timing.
	typedef enum logic [1:0] {
		ECD_PH1,
		ECD_PH2,
		ECD_PH3,
		ECD_PH4
	} ecd_phase_e;

	// One-cycle strobes that mark the start of each phase slot.
	typedef struct packed {
		logic p1;
		logic p2;
		logic p3;
		logic p4;
	} ecd_phase_s;

	// Signed step request from the guidance computer.
	typedef struct packed {
		logic pos;
		logic neg;
	} ecd_step_s;

endpackage : ecd_pkg

// file: verilog/ecd_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ecd_sync #(
	parameter int unsigned WIDTH = 2
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// Asynchronous input and its clean copy
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	import ecd_pkg::*;

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A bit changes only once the second and third stages agree.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_out <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					sync_out[i] <= stage3[i];
				end
			end
		end
	end

endmodule : ecd_sync

`default_nettype wire

// file: verilog/ecd_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none

module ecd_phase_gen #(
	parameter int unsigned SLOT_CYCLES = ecd_pkg::PHASE_CYCLES
) (
	// Clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	// Phase strobes
	output var  ecd_pkg::ecd_phase_s phase
);
	import ecd_pkg::*;

	localparam int unsigned CNT_W = $clog2(SLOT_CYCLES + 1);
	localparam logic [CNT_W-1:0] SLOT_LAST = CNT_W'(SLOT_CYCLES - 1);

	ecd_phase_e       slot;
	ecd_phase_e       next_slot;
	logic [CNT_W-1:0] slot_cnt;
	logic             slot_end;

	assign slot_end = (slot_cnt == SLOT_LAST);

	always_comb begin
		next_slot = slot;
		unique case (slot)
			ECD_PH1: next_slot = ECD_PH2;
			ECD_PH2: next_slot = ECD_PH3;
			ECD_PH3: next_slot = ECD_PH4;
			ECD_PH4: next_slot = ECD_PH1;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			slot_cnt <= '0;
			slot     <= ECD_PH4;
		end else if (slot_end) begin
			slot_cnt <= '0;
			slot     <= next_slot;
		end else begin
			slot_cnt <= slot_cnt + CNT_W'(1);
		end
	end

	// Each strobe is high for the first cycle of its slot.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase <= '0;
		end else begin
			phase.p1 <= slot_end && (next_slot == ECD_PH1);
			phase.p2 <= slot_end && (next_slot == ECD_PH2);
			phase.p3 <= slot_end && (next_slot == ECD_PH3);
			phase.p4 <= slot_end && (next_slot == ECD_PH4);
		end
	end

endmodule : ecd_phase_gen

`default_nettype wire

// file: verilog/ecd_dir_ctrl.sv
// How it works
// - Selected polarity pulses occur only at phase two.
// - Computer polarity pulse on next phase-two slot.
// - Hold window blocks feedback polarity pulses.
// - Feedback polarity selected only under coarse align.
// - Sign flip-flop changes only at zero count.
// - Zero plus up pulse sets positive sign.
// - Zero plus down pulse sets negative sign.
// - Count down only while count is nonzero.
// - Up with positive or down with negative: up.
// - Down with positive or up with negative: down.
// - Zero flag blocks count down until incremented.
// - Up and down commands complementary from one flop.
// - Counter held at zero until enabled.
// - Zero flag follows counter contents.
// - Feedback up direction yields selected down pulse.
// - Feedback steps decrement under count down command.
// - Increment pulses issued at phase four.
// - Computer step inhibits read counter incrementing in coarse align, unless saturated.
// - Direction decided at phase two, counting at four.
// - Feedback inputs give read counter direction.
// - Saturation flag blocks counting up beyond limit.
`timescale 1ns/1ps
`default_nettype none

module ecd_dir_ctrl #(
	parameter int unsigned SLOT_CYCLES = ecd_pkg::PHASE_CYCLES
) (
	// Clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        arst_n,
	// Guidance computer step pins
	input  wire ecd_pkg::ecd_step_s          cmd_step,
	// Read counter feedback
	input  wire logic                        fb_dir_pos,
	input  wire logic                        fb_dir_neg,
	input  wire logic                        fb_step,
	// Mode discretes
	input  wire logic                        coarse_align_en,
	input  wire logic                        counter_enable,
	// Selected polarity pulses and synchronised computer step
	output logic                             sel_pos_pulse,
	output logic                             sel_neg_pulse,
	output logic                             cmd_step_sync,
	// Converter sign
	output logic                             dac_pos_sign,
	output logic                             dac_neg_sign,
	// Count direction and stepping
	output logic                             cnt_rise_cmd,
	output logic                             cnt_fall_cmd,
	output logic                             counter_step_pulse,
	output logic                             read_inhibit,
	// Counter status
	output logic                             count_zero_flag,
	output logic                             sat_flag,
	output logic [ecd_pkg::COUNT_W-1:0]      count_value
);
	import ecd_pkg::*;

	// Reset release.
	logic [1:0] rst_pipe;
	logic       rst_n;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end

	assign rst_n = rst_pipe[1];

	// Timing and input conditioning.
	ecd_phase_s phase;
	ecd_step_s  step_clean;
	ecd_step_s  step_prev;
	logic       arrive_pos;
	logic       arrive_neg;

	ecd_phase_gen #(
		.SLOT_CYCLES (SLOT_CYCLES)
	) u_phase (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.phase   (phase)
	);

	ecd_sync #(
		.WIDTH (2)
	) u_sync (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.async_in (cmd_step),
		.sync_out (step_clean)
	);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			step_prev <= '0;
		end else begin
			step_prev <= step_clean;
		end
	end

	assign arrive_pos = step_clean.pos && !step_prev.pos;
	assign arrive_neg = step_clean.neg && !step_prev.neg;

	// State.
	logic                step_pend;
	logic                hold_win;
	logic                cmd_pol;
	logic                incr_pend;
	logic                fb_pend;
	logic                sign_pos;
	logic                dir_up;
	logic                sat_hold;
	logic [COUNT_W-1:0]  count;

	// Decisions made in the current cycle.
	logic                sync_now;
	logic                cmd_up;
	logic                cmd_dn;
	logic                fb_up;
	logic                fb_dn;
	logic                sel_up;
	logic                sel_dn;
	logic                zero_now;
	logic                at_sat;
	logic                next_sign_pos;
	logic                next_dir_up;
	logic                step_now;
	logic                step_cmd;

	assign zero_now = (count == ZERO_COUNT);
	assign at_sat   = dir_up && (count == SAT_COUNT);

	// The single computer-derived pulse falls in the window at phase two.
	assign sync_now = phase.p2 && hold_win && step_pend;
	assign cmd_up   = sync_now && cmd_pol;
	assign cmd_dn   = sync_now && !cmd_pol;

	// Feedback polarity: read counter counting up means the gimbal caught up, so count down.
	assign fb_up = phase.p2 && coarse_align_en && !hold_win && fb_dir_neg;
	assign fb_dn = phase.p2 && coarse_align_en && !hold_win && fb_dir_pos;

	assign sel_up = cmd_up || fb_up;
	assign sel_dn = cmd_dn || fb_dn;

	// The sign only moves while the counter holds zero.
	always_comb begin
		next_sign_pos = sign_pos;
		if (zero_now && sel_up) begin
			next_sign_pos = 1'b1;
		end else if (zero_now && sel_dn) begin
			next_sign_pos = 1'b0;
		end
	end

	// Direction follows the pulse against the sign being established in this cycle.
	always_comb begin
		next_dir_up = dir_up;
		if ((sel_up && next_sign_pos) || (sel_dn && !next_sign_pos)) begin
			next_dir_up = 1'b1;
		end else if (((sel_dn && next_sign_pos) || (sel_up && !next_sign_pos)) && !zero_now) begin
			next_dir_up = 1'b0;
		end
	end

	// A pending computer step wins the phase-four slot over feedback.
	assign step_cmd = incr_pend;
	assign step_now = phase.p4 && counter_enable && (step_cmd || (fb_pend && coarse_align_en));

	// First flip-flop of the step catcher; merges steps that arrive before the pulse.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			step_pend <= 1'b0;
		end else if (arrive_pos || arrive_neg) begin
			step_pend <= 1'b1;
		end else if (sync_now) begin
			step_pend <= 1'b0;
		end
	end

	// Hold window from the phase-one slot after a step to the next phase three.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hold_win <= 1'b0;
		end else if (phase.p1 && step_pend) begin
			hold_win <= 1'b1;
		end else if (phase.p3) begin
			hold_win <= 1'b0;
		end
	end

	// Polarity of the latest computer step.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmd_pol <= RST_CMD_POL;
		end else if (arrive_pos) begin
			cmd_pol <= 1'b1;
		end else if (arrive_neg) begin
			cmd_pol <= 1'b0;
		end
	end

	// Increment request from phase two until the next phase one.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			incr_pend <= 1'b0;
		end else if (sync_now) begin
			incr_pend <= 1'b1;
		end else if (phase.p1) begin
			incr_pend <= 1'b0;
		end
	end

	// Feedback step waits for a free phase-four slot; outside coarse align it is dropped.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fb_pend <= 1'b0;
		end else if (fb_step && coarse_align_en) begin
			fb_pend <= 1'b1;
		end else if (!coarse_align_en || (step_now && !step_cmd)) begin
			fb_pend <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sign_pos <= RST_SIGN_POS;
		end else begin
			sign_pos <= next_sign_pos;
		end
	end

	// Direction only changes on phase-two selected pulses, and returns to up while the counter is disabled.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dir_up <= RST_DIR_UP;
		end else if (!counter_enable) begin
			dir_up <= RST_DIR_UP;
		end else begin
			dir_up <= next_dir_up;
		end
	end

	// Saturation stays while up is kept at the limit; a pulse that turns the count down ends it.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sat_hold <= 1'b0;
		end else if (at_sat && next_dir_up) begin
			sat_hold <= 1'b1;
		end else if (sel_up || sel_dn || !counter_enable) begin
			sat_hold <= 1'b0;
		end
	end

	// Error counter magnitude.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			count <= ZERO_COUNT;
		end else if (!counter_enable) begin
			count <= ZERO_COUNT;
		end else if (step_now && dir_up && !at_sat && !sat_hold) begin
			count <= count + COUNT_W'(1);
		end else if (step_now && !dir_up && !zero_now) begin
			count <= count - COUNT_W'(1);
		end
	end

	// Registered pulse outputs, one cycle after the decision.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sel_pos_pulse      <= 1'b0;
			sel_neg_pulse      <= 1'b0;
			cmd_step_sync      <= 1'b0;
			counter_step_pulse <= 1'b0;
		end else begin
			sel_pos_pulse      <= sel_up;
			sel_neg_pulse      <= sel_dn;
			cmd_step_sync      <= sync_now;
			counter_step_pulse <= step_now;
		end
	end

	assign dac_pos_sign    = sign_pos;
	assign dac_neg_sign    = !sign_pos;
	assign cnt_rise_cmd    = dir_up;
	assign cnt_fall_cmd    = !dir_up;
	assign count_zero_flag = zero_now;
	assign sat_flag        = at_sat || sat_hold;
	assign count_value     = count;

	// Read counter is held off from the phase-one after a step to the next phase one.
	assign read_inhibit = coarse_align_en && !sat_flag && (hold_win || incr_pend);

endmodule : ecd_dir_ctrl

`default_nettype wire

// file: tb/ecd_dir_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none

module ecd_dir_ctrl_checker #(
	parameter int unsigned SLOT_CYCLES = ecd_pkg::PHASE_CYCLES
) (
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   arst_n,
	// Watched pins
	input  wire logic                   coarse_align_en,
	input  wire logic                   counter_enable,
	input  wire logic                   sel_pos_pulse,
	input  wire logic                   sel_neg_pulse,
	input  wire logic                   cmd_step_sync,
	input  wire logic                   dac_pos_sign,
	input  wire logic                   dac_neg_sign,
	input  wire logic                   cnt_rise_cmd,
	input  wire logic                   cnt_fall_cmd,
	input  wire logic                   counter_step_pulse,
	input  wire logic                   read_inhibit,
	input  wire logic                   count_zero_flag,
	input  wire logic                   sat_flag,
	input  wire logic [ecd_pkg::COUNT_W-1:0] count_value
);
	import ecd_pkg::*;
	localparam int STEP_LAG = 2 * SLOT_CYCLES;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	// Cycles left until the increment that a synchronised step must produce.
	int lag_left;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			lag_left <= 0;
		end else if (cmd_step_sync && counter_enable && !sat_flag) begin
			lag_left <= STEP_LAG - 1;
		end else if (lag_left != 0) begin
			lag_left <= lag_left - 1;
		end
	end

	chk_sign_pair: assert property (dac_neg_sign == !dac_pos_sign)
		else $error("sign outputs not complementary");
	chk_dir_pair: assert property (cnt_fall_cmd == !cnt_rise_cmd)
		else $error("direction outputs not complementary");
	chk_sign_hold: assert property (!count_zero_flag && !$past(count_zero_flag) |-> $stable(dac_pos_sign))
		else $error("sign changed at nonzero count");
	chk_pos_sign: assert property (sel_pos_pulse && count_zero_flag |-> dac_pos_sign)
		else $error("up pulse at zero left sign negative");
	chk_neg_sign: assert property (sel_neg_pulse && count_zero_flag |-> !dac_pos_sign)
		else $error("down pulse at zero left sign positive");
	chk_dir_up: assert property (sel_pos_pulse && dac_pos_sign || sel_neg_pulse && !dac_pos_sign |-> cnt_rise_cmd)
		else $error("count up not commanded");
	chk_dir_down: assert property ((sel_neg_pulse && dac_pos_sign || sel_pos_pulse && !dac_pos_sign)
		&& !count_zero_flag && counter_enable |-> cnt_fall_cmd)
		else $error("count down not commanded");
	chk_zero_no_dec: assert property (count_zero_flag && cnt_fall_cmd |=> count_value == ZERO_COUNT)
		else $error("counter decremented below zero");
	chk_held_zero: assert property (!counter_enable |=> count_value == ZERO_COUNT)
		else $error("counter not held at zero");
	chk_zero_flag: assert property (count_zero_flag == (count_value == ZERO_COUNT))
		else $error("zero flag disagrees with count");
	chk_step_lag: assert property (lag_left == 1 |=> counter_step_pulse)
		else $error("increment not two slots after decision");
	chk_ca_only: assert property ((sel_pos_pulse || sel_neg_pulse) && !coarse_align_en
		&& !$past(coarse_align_en) |-> cmd_step_sync)
		else $error("feedback polarity selected outside coarse align");
	chk_inhibit_on: assert property (cmd_step_sync && coarse_align_en && !sat_flag |-> read_inhibit)
		else $error("read counter not inhibited");
	chk_cmd_pulse: assert property (cmd_step_sync |-> sel_pos_pulse || sel_neg_pulse)
		else $error("computer step gave no polarity pulse");
	chk_sat_block: assert property (cnt_rise_cmd && count_value == SAT_COUNT && counter_enable
		|-> sat_flag ##1 count_value == SAT_COUNT)
		else $error("counter not stopped at saturation");
	chk_sat_only_up: assert property (cnt_fall_cmd |-> !sat_flag)
		else $error("saturation flag while counting down");

	cov_cmd: cover property (cmd_step_sync);
	cov_fb: cover property (sel_neg_pulse && coarse_align_en && !cmd_step_sync);
	cov_down: cover property (counter_step_pulse && cnt_fall_cmd);
	cov_sat: cover property (counter_step_pulse && sat_flag);
endmodule : ecd_dir_ctrl_checker

bind ecd_dir_ctrl ecd_dir_ctrl_checker #(.SLOT_CYCLES(SLOT_CYCLES)) u_chk (
	.clk_sys(clk_sys), .arst_n(arst_n), .coarse_align_en(coarse_align_en),
	.counter_enable(counter_enable), .sel_pos_pulse(sel_pos_pulse), .sel_neg_pulse(sel_neg_pulse),
	.cmd_step_sync(cmd_step_sync), .dac_pos_sign(dac_pos_sign), .dac_neg_sign(dac_neg_sign),
	.cnt_rise_cmd(cnt_rise_cmd), .cnt_fall_cmd(cnt_fall_cmd),
	.counter_step_pulse(counter_step_pulse), .read_inhibit(read_inhibit),
	.count_zero_flag(count_zero_flag), .sat_flag(sat_flag), .count_value(count_value));

`default_nettype wire

// file: tb/ecd_cmd_model.sv
`timescale 1ns/1ps
`default_nettype none

module ecd_cmd_model (
	// Clock
	input  wire logic          clk_sys,
	// Step request from the bench
	input  wire logic          req,
	input  wire logic          req_pos,
	// Step pins
	output var  ecd_pkg::ecd_step_s cmd_step
);
	import ecd_pkg::*;
	logic       pol = 1'b0;
	logic [2:0] left = 3'h0;

	// A step pin stays high four clocks so the three-stage synchroniser sees it.
	always_ff @(posedge clk_sys) begin
		if (req) begin
			pol  <= req_pos;
			left <= 3'h4;
		end else if (left != 3'h0) begin
			left <= left - 3'h1;
		end
	end

	assign cmd_step = '{pos: pol && left != 3'h0, neg: !pol && left != 3'h0};
endmodule : ecd_cmd_model

`default_nettype wire

// file: tb/tb_ecd_dir_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module tb_ecd_dir_ctrl;
	import ecd_pkg::*;
	localparam int unsigned SLOT = 4;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic req = 1'b0;
	logic req_pos = 1'b0;
	logic fb_dir_pos = 1'b0;
	logic fb_dir_neg = 1'b0;
	logic fb_step = 1'b0;
	logic coarse_align_en = 1'b0;
	logic counter_enable = 1'b0;
	ecd_step_s cmd_step;
	logic sel_pos_pulse, sel_neg_pulse, cmd_step_sync, dac_pos_sign, dac_neg_sign, read_inhibit;
	logic cnt_rise_cmd, cnt_fall_cmd, counter_step_pulse, count_zero_flag, sat_flag;
	logic [COUNT_W-1:0] count_value;
	logic [10:0] exp_q[$];
	int bad_count = 0;
	int samples_checked = 0;
	logic m_sign = 1'b1;
	logic m_dir = 1'b1;
	logic [8:0] m_count = 9'h000;

	initial begin
		forever #10 clk_sys = ~clk_sys;
	end

	ecd_cmd_model u_cmd (.clk_sys(clk_sys), .req(req), .req_pos(req_pos), .cmd_step(cmd_step));

	ecd_dir_ctrl #(.SLOT_CYCLES(SLOT)) uut (
		.clk_sys(clk_sys), .arst_n(arst_n), .cmd_step(cmd_step), .fb_dir_pos(fb_dir_pos),
		.fb_dir_neg(fb_dir_neg), .fb_step(fb_step), .coarse_align_en(coarse_align_en),
		.counter_enable(counter_enable), .sel_pos_pulse(sel_pos_pulse),
		.sel_neg_pulse(sel_neg_pulse), .cmd_step_sync(cmd_step_sync), .dac_pos_sign(dac_pos_sign),
		.dac_neg_sign(dac_neg_sign), .cnt_rise_cmd(cnt_rise_cmd), .cnt_fall_cmd(cnt_fall_cmd),
		.counter_step_pulse(counter_step_pulse), .read_inhibit(read_inhibit),
		.count_zero_flag(count_zero_flag), .sat_flag(sat_flag), .count_value(count_value));

	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	// Expected state after one turn: decision at phase two, count at phase four.
	task automatic predict(input logic p);
		if (m_count == ZERO_COUNT) begin
			m_sign = p;
			m_dir = 1'b1;
		end else begin
			m_dir = (p == m_sign);
		end
		if (m_dir && m_count != SAT_COUNT) begin
			m_count++;
		end else if (!m_dir && m_count != ZERO_COUNT) begin
			m_count--;
		end
		exp_q.push_back({m_sign, m_dir, m_count});
	endtask : predict

	task automatic wait_step();
		int n;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (counter_step_pulse !== 1'b1 && n < 64);
	endtask : wait_step

	task automatic step(input logic p);
		@(negedge clk_sys);
		req = 1'b1;
		req_pos = p;
		predict(p);
		@(negedge clk_sys);
		req = 1'b0;
		wait_step();
	endtask : step

	// Called just after an increment, so the levels span exactly one phase two.
	task automatic feedback(input logic dpos);
		fb_dir_pos = dpos;
		fb_dir_neg = !dpos;
		fb_step = 1'b1;
		if (coarse_align_en) begin
			predict(!dpos);
		end
		@(negedge clk_sys);
		fb_step = 1'b0;
		repeat (15) @(negedge clk_sys);
		fb_dir_pos = 1'b0;
		fb_dir_neg = 1'b0;
		if (coarse_align_en) begin
			wait_step();
		end else begin
			repeat (48) @(negedge clk_sys);
		end
	endtask : feedback

	always @(negedge clk_sys) begin
		if (counter_step_pulse === 1'b1) begin
			check({dac_pos_sign, cnt_rise_cmd, count_value}, exp_q.size() != 0 ? exp_q.pop_front() : 11'h7FF);
		end
	end

	initial begin
		logic p;
		void'($urandom(74281));
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		arst_n = 1'b1;
		repeat (12) @(negedge clk_sys);
		check({2'b00, count_value}, 11'h000);
		counter_enable = 1'b1;
		for (int i = 0; i < 16; i++) begin
			p = (i < 6) ? 1'(6'b100011 >> i) : 1'($urandom);
			repeat ($urandom % 8) @(negedge clk_sys);
			step(p);
		end
		while (m_count != SAT_COUNT) begin
			step(m_sign);
		end
		step(m_sign);
		check({10'h000, sat_flag}, 11'h001);
		step(!m_sign);
		check({10'h000, sat_flag}, 11'h000);
		coarse_align_en = 1'b1;
		step(1'b1);
		for (int i = 0; i < 3; i++) begin
			feedback(m_sign);
		end
		coarse_align_en = 1'b0;
		feedback(!m_sign);
		check({dac_pos_sign, cnt_rise_cmd, count_value}, {m_sign, m_dir, m_count});
		counter_enable = 1'b0;
		repeat (2) @(negedge clk_sys);
		check({1'b0, cnt_rise_cmd, count_value}, {2'b01, ZERO_COUNT});
		check(11'(exp_q.size()), 11'h000);
		test_done();
	end

	initial begin
		repeat (30000) @(posedge clk_sys);
		bad_count++;
		test_done();
	end
endmodule : tb_ecd_dir_ctrl

`default_nettype wire
